// ==== src/ira_regs.svh ====
// Register offsets, fields, reset values and page codes of the indirect access block
// What this block does
// [RQ1] Page select: 000 off, 001 port0, 010 port1
// [RQ2] Auto-step adds one after each data access
// [RQ3] Software sets read intent with auto-step
// [RQ4] Software: intent one for reads, zero writes
// [RQ5] Status clears on read only with intent
// [RQ6] Offset write with intent strobes analog read
// [RQ7] Data read with auto-step and intent prefetches next location
// [RQ8] Eight-bit writable offset selects target register
// [RQ9] Data register writes and reads target register
// [RQ10] Disabled page: no writes, reads return zero
`ifndef IRA_REGS_SVH
`define IRA_REGS_SVH

`define IRA_CTL_OFS 8'h40
`define IRA_OFS_OFS 8'h41
`define IRA_DAT_OFS 8'h42

`define IRA_CTL_RST 8'h00
`define IRA_OFS_RST 8'h00
`define IRA_DAT_RST 8'h00
`define IRA_CTL_WMASK 8'h1F

`define IRA_SEL_MSB 4
`define IRA_SEL_LSB 2
`define IRA_STEP_BIT 1
`define IRA_INTENT_BIT 0

`define IRA_PAGE_OFF 3'h0
`define IRA_PAGE_P0 3'h1
`define IRA_PAGE_P1 3'h2

`define IRA_STEP 8'h01
`define IRA_ZERO 8'h00

`endif

// ==== src/ira_pkg.sv ====
// Types shared by the indirect access block
package ira_pkg;
  typedef logic [7:0] ira_byte_t;
  typedef logic [2:0] ira_sel_t;
  typedef enum logic [1:0] {
    IRA_PG_OFF,
    IRA_PG_PORT0,
    IRA_PG_PORT1,
    IRA_PG_RSVD
  } ira_page_t;
endpackage : ira_pkg

// ==== src/ira_top.sv ====
// Indirect register access controller with host register port and target access port
`timescale 1ns/1ps
`default_nettype none
`include "ira_regs.svh"

module ira_top (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ce,
  input wire ira_pkg::ira_byte_t reg_addr,
  input wire ira_pkg::ira_byte_t reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output ira_pkg::ira_byte_t reg_rdata,
  output ira_pkg::ira_sel_t tgt_page,
  output ira_pkg::ira_byte_t tgt_addr,
  input wire ira_pkg::ira_byte_t tgt_rdata,
  output logic tgt_wr,
  output ira_pkg::ira_byte_t tgt_wr_data,
  output ira_pkg::ira_byte_t tgt_acc_addr,
  output ira_pkg::ira_sel_t tgt_acc_page,
  output logic tgt_rd_done,
  output logic tgt_rd_clear,
  output logic ana_rd_stb
);
  import ira_pkg::*;

  // Reset release through two flops; assertion stays asynchronous
  logic rst_s1_q;
  logic rst_n_q;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  function automatic ira_page_t page_decode(input ira_sel_t sel);
    ira_page_t p;
    p = IRA_PG_RSVD;
    case (sel)
      `IRA_PAGE_OFF: p = IRA_PG_OFF;
      `IRA_PAGE_P0: p = IRA_PG_PORT0;
      `IRA_PAGE_P1: p = IRA_PG_PORT1;
      default: p = IRA_PG_RSVD;
    endcase
    return p;
  endfunction : page_decode

  // Reserved codes behave like the disabled code
  function automatic logic page_live(input ira_sel_t sel);
    ira_page_t p;
    p = page_decode(sel);
    return (p == IRA_PG_PORT0) || (p == IRA_PG_PORT1);
  endfunction : page_live

  ira_byte_t ctl_q;
  ira_byte_t offset_q;
  ira_byte_t data_q;
  ira_byte_t rdata_q;
  ira_byte_t wr_data_q;
  ira_byte_t acc_addr_q;
  ira_sel_t acc_page_q;
  logic wr_q;
  logic rd_done_q;
  logic rd_clear_q;
  logic ana_stb_q;

  logic hit_ctl;
  logic hit_ofs;
  logic hit_dat;
  logic data_wr;
  logic data_rd;
  logic ofs_wr;
  logic live;
  logic auto_step;
  logic read_intent;
  ira_sel_t page_sel;

  // Address decode
  always_comb begin
    hit_ctl = 1'b0;
    hit_ofs = 1'b0;
    hit_dat = 1'b0;
    if (reg_addr == `IRA_CTL_OFS) begin
      hit_ctl = 1'b1;
    end else if (reg_addr == `IRA_OFS_OFS) begin
      hit_ofs = 1'b1;
    end else if (reg_addr == `IRA_DAT_OFS) begin
      hit_dat = 1'b1;
    end
  end

  assign page_sel = ctl_q[`IRA_SEL_MSB:`IRA_SEL_LSB];
  assign auto_step = ctl_q[`IRA_STEP_BIT];
  assign read_intent = ctl_q[`IRA_INTENT_BIT];
  assign live = page_live(page_sel); // [RQ1]
  assign data_wr = ce && reg_wr && hit_dat;
  assign data_rd = ce && reg_rd && hit_dat;
  assign ofs_wr = ce && reg_wr && hit_ofs;

  // Control register; reserved bits stay zero
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ctl_q <= `IRA_CTL_RST;
    end else if (ce && reg_wr && hit_ctl) begin
      ctl_q <= reg_wdata & `IRA_CTL_WMASK; // [RQ1]
    end
  end

  // Offset: a direct write beats the auto step
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      offset_q <= `IRA_OFS_RST;
    end else if (ofs_wr) begin
      offset_q <= reg_wdata; // [RQ8]
    end else if (auto_step && (data_wr || data_rd)) begin
      offset_q <= offset_q + `IRA_STEP; // [RQ2]
    end
  end

  // Last value written to the data register
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      data_q <= `IRA_DAT_RST;
    end else if (data_wr) begin
      data_q <= reg_wdata;
    end
  end

  // Target write pulse carries the pre-step offset and page
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_q <= 1'b0;
      wr_data_q <= `IRA_ZERO;
      acc_addr_q <= `IRA_ZERO;
      acc_page_q <= `IRA_PAGE_OFF;
    end else if (ce) begin
      wr_q <= data_wr && live; // [RQ9] [RQ10]
      if (data_wr) begin
        wr_data_q <= reg_wdata;
      end
      if (data_wr || data_rd) begin
        acc_addr_q <= offset_q;
        acc_page_q <= page_sel;
      end
    end
  end

  // Read completion: target may clear status only when told to
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_done_q <= 1'b0;
      rd_clear_q <= 1'b0;
    end else if (ce) begin
      rd_done_q <= data_rd && live;
      rd_clear_q <= data_rd && live && read_intent; // [RQ5]
    end
  end

  // Analog prefetch strobe, address is the offset after update
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ana_stb_q <= 1'b0;
    end else if (ce) begin
      ana_stb_q <= (ofs_wr && read_intent) // [RQ6]
        || (data_rd && auto_step && read_intent); // [RQ7]
    end
  end

  // Read data stands for one enabled cycle only, zero otherwise
  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= `IRA_ZERO;
    end else if (ce) begin
      if (reg_rd && hit_ctl) begin
        rdata_q <= ctl_q;
      end else if (reg_rd && hit_ofs) begin
        rdata_q <= offset_q;
      end else if (reg_rd && hit_dat) begin
        rdata_q <= live ? tgt_rdata : `IRA_ZERO; // [RQ9] [RQ10]
      end else begin
        rdata_q <= `IRA_ZERO;
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign tgt_page = page_sel;
  assign tgt_addr = offset_q;
  assign tgt_wr = wr_q;
  assign tgt_wr_data = wr_data_q;
  assign tgt_acc_addr = acc_addr_q;
  assign tgt_acc_page = acc_page_q;
  assign tgt_rd_done = rd_done_q;
  assign tgt_rd_clear = rd_clear_q;
  assign ana_rd_stb = ana_stb_q;

  default clocking ira_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n_q);

  sequence s_data_read;
    data_rd;
  endsequence

  sequence s_data_write;
    data_wr;
  endsequence

  sequence s_stepped_read;
    s_data_read ##0 (auto_step && read_intent);
  endsequence

  AST_PAGE_DECODE: assert property ( // [RQ1]
    live == ((page_sel == `IRA_PAGE_P0) || (page_sel == `IRA_PAGE_P1)))
    else $error("page decode wrong");

  AST_AUTO_STEP: assert property ( // [RQ2]
    (s_data_read or s_data_write) ##0 (auto_step && !ofs_wr) |=> offset_q == $past(offset_q) + `IRA_STEP)
    else $error("offset did not step");

  AST_NO_STEP: assert property ( // [RQ2]
    (ce && !ofs_wr && !(auto_step && (data_wr || data_rd))) |=> $stable(offset_q))
    else $error("offset moved without cause");

  AST_CLEAR_INTENT: assert property ( // [RQ5]
    s_data_read ##0 live |=> tgt_rd_done && (tgt_rd_clear == $past(read_intent)))
    else $error("clear on read mismatch");

  AST_NO_CLEAR: assert property ( // [RQ5]
    tgt_rd_clear |-> tgt_rd_done)
    else $error("clear without read");

  AST_PREFETCH_OFS: assert property ( // [RQ6]
    (ofs_wr && read_intent) |=> ana_rd_stb && tgt_addr == $past(reg_wdata))
    else $error("no prefetch on offset write");

  AST_PREFETCH_READ: assert property ( // [RQ7]
    s_stepped_read |=> ana_rd_stb ##0 (tgt_addr == $past(offset_q) + `IRA_STEP))
    else $error("no prefetch after stepped read");

  AST_NO_STROBE: assert property ( // [RQ6]
    (ce && !read_intent) |=> !ana_rd_stb)
    else $error("strobe without read intent");

  AST_OFS_WRITE: assert property ( // [RQ8]
    ofs_wr ##1 (ce && reg_rd && hit_ofs && !ofs_wr) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("offset readback wrong");

  AST_WR_FORWARD: assert property ( // [RQ9]
    s_data_write ##0 live |=> tgt_wr && tgt_wr_data == $past(reg_wdata) && tgt_acc_addr == $past(offset_q))
    else $error("indirect write not forwarded");

  AST_RD_FORWARD: assert property ( // [RQ9]
    s_data_read ##0 live |=> reg_rdata == $past(tgt_rdata))
    else $error("indirect read value wrong");

  AST_DISABLED: assert property ( // [RQ10]
    (s_data_read or s_data_write) ##0 !live |=> !tgt_wr && !tgt_rd_done && reg_rdata == `IRA_ZERO)
    else $error("disabled page accessed");

  // Freeze: a low enable must hold the offset and control registers
  AST_FREEZE_OFS: assert property ( // [RQ8]
    (!ce) |=> $stable(offset_q))
    else $error("offset moved while frozen");

  AST_FREEZE_CTL: assert property ( // [RQ1]
    (!ce) |=> $stable(ctl_q))
    else $error("control moved while frozen");

  AST_CTL_RSVD: assert property ( // [RQ1]
    (ctl_q & ~`IRA_CTL_WMASK) == `IRA_ZERO)
    else $error("reserved control bits set");

  AST_CTL_READ: assert property ( // [RQ1]
    (ce && reg_rd && hit_ctl) |=> reg_rdata == $past(ctl_q))
    else $error("control readback wrong");

  AST_OFS_LOAD: assert property ( // [RQ8]
    ofs_wr |=> tgt_addr == $past(reg_wdata))
    else $error("offset not loaded");

  AST_RDATA_IDLE: assert property ( // [RQ9]
    (ce && !reg_rd) |=> reg_rdata == `IRA_ZERO)
    else $error("read data outside its cycle");

  AST_WR_PAGE: assert property ( // [RQ9]
    s_data_write |=> tgt_acc_page == $past(page_sel))
    else $error("write page not forwarded");

  AST_READ_NO_WRITE: assert property ( // [RQ9]
    s_data_read |=> !tgt_wr)
    else $error("read caused target write");

  AST_RD_ADDR: assert property ( // [RQ9]
    s_data_read ##0 live |=> tgt_acc_addr == $past(offset_q) && tgt_acc_page == $past(page_sel))
    else $error("read location not forwarded");

endmodule : ira_top
`default_nettype wire

// ==== testbench/ira_tgt_model.sv ====
// Target page model: two digital pages, clear on read
`timescale 1ns/1ps
`default_nettype none
module ira_tgt_model (
  input wire logic mclk,
  input wire ira_pkg::ira_sel_t tgt_page,
  input wire ira_pkg::ira_byte_t tgt_addr,
  output ira_pkg::ira_byte_t tgt_rdata,
  input wire logic tgt_wr,
  input wire ira_pkg::ira_byte_t tgt_wr_data,
  input wire ira_pkg::ira_byte_t tgt_acc_addr,
  input wire ira_pkg::ira_sel_t tgt_acc_page,
  input wire logic tgt_rd_clear
);
  import ira_pkg::*;
  ira_byte_t mem_q [2][256];
  logic acc_ok;
  initial mem_q = '{default: 8'h00};
  assign acc_ok = (tgt_acc_page == 3'h1) || (tgt_acc_page == 3'h2);
  // No page selected: a pattern, never zero, so a leak shows
  assign tgt_rdata = (tgt_page == 3'h1 || tgt_page == 3'h2) ? mem_q[tgt_page[1]][tgt_addr] : 8'hA5;
  always @(posedge mclk) begin
    if (tgt_wr && acc_ok) begin
      mem_q[tgt_acc_page[1]][tgt_acc_addr] <= tgt_wr_data;
    end
    if (tgt_rd_clear && acc_ok) begin
      mem_q[tgt_acc_page[1]][tgt_acc_addr] <= 8'h00;
    end
  end
endmodule : ira_tgt_model
`default_nettype wire

// ==== testbench/indirect_register_access_bench.sv ====
// Self-checking bench of the indirect access block
`timescale 1ns/1ps
`default_nettype none
`include "ira_regs.svh"
module indirect_register_access_bench;
  import ira_pkg::*;
  logic mclk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, ce = 1;
  ira_byte_t reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, tgt_addr, tgt_rdata, tgt_wr_data, tgt_acc_addr, v;
  ira_sel_t tgt_page, tgt_acc_page;
  logic tgt_wr, tgt_rd_done, tgt_rd_clear, ana_rd_stb;
  int miscompares = 0, n_checks = 0;
  always #5 mclk = ~mclk;
  ira_top dut (.mclk(mclk), .rst_b(rst_b), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tgt_page(tgt_page), .tgt_addr(tgt_addr),
    .tgt_rdata(tgt_rdata), .tgt_wr(tgt_wr), .tgt_wr_data(tgt_wr_data), .tgt_acc_addr(tgt_acc_addr),
    .tgt_acc_page(tgt_acc_page), .tgt_rd_done(tgt_rd_done), .tgt_rd_clear(tgt_rd_clear), .ana_rd_stb(ana_rd_stb));
  ira_tgt_model tgt (.mclk(mclk), .tgt_page(tgt_page), .tgt_addr(tgt_addr), .tgt_rdata(tgt_rdata),
    .tgt_wr(tgt_wr), .tgt_wr_data(tgt_wr_data), .tgt_acc_addr(tgt_acc_addr), .tgt_acc_page(tgt_acc_page),
    .tgt_rd_clear(tgt_rd_clear));
  task automatic chk(input ira_byte_t got, input ira_byte_t exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Returns 1 ns past the taking edge, so pulses are settled
  task automatic wr(input ira_byte_t a, input ira_byte_t d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input ira_byte_t a, output ira_byte_t got);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    got = reg_rdata;
  endtask : rd
  task automatic t_reset;
    rd(`IRA_CTL_OFS, v); chk(v, 8'h00);
    rd(`IRA_OFS_OFS, v); chk(v, 8'h00);
    rd(8'h43, v); chk(v, 8'h00);
    wr(`IRA_CTL_OFS, 8'hFF);
    rd(`IRA_CTL_OFS, v); chk(v, 8'h1F);
    wr(`IRA_OFS_OFS, 8'hFF); chk(tgt_addr, 8'hFF);
    wr(`IRA_DAT_OFS, 8'h5A); chk({7'h00, tgt_wr}, 8'h00);
    rd(`IRA_DAT_OFS, v); chk({tgt_rd_done, v[6:0]}, 8'h00);
    $display("done reset and control");
  endtask : t_reset
  task automatic t_pages;
    for (int p = 0; p < 3; p++) begin
      wr(`IRA_CTL_OFS, 8'(p << 2));
      chk({5'h00, tgt_page}, 8'(p));
      wr(`IRA_OFS_OFS, 8'h10);
      wr(`IRA_DAT_OFS, 8'(8'h30 + p));
      chk({7'h00, tgt_wr}, {7'h00, p != 0});
      chk({5'h00, tgt_acc_page}, 8'(p));
      chk(tgt_wr_data, 8'(8'h30 + p));
      rd(`IRA_DAT_OFS, v); chk(v, (p == 0) ? 8'h00 : 8'(8'h30 + p));
      chk({7'h00, tgt_rd_done}, {7'h00, p != 0});
    end
    $display("done pages");
  endtask : t_pages
  task automatic t_step;
    wr(`IRA_CTL_OFS, 8'h06);
    wr(`IRA_OFS_OFS, 8'h20); chk({7'h00, ana_rd_stb}, 8'h00);
    wr(`IRA_DAT_OFS, 8'h11); chk(tgt_acc_addr, 8'h20);
    wr(`IRA_DAT_OFS, 8'h22); chk(tgt_addr, 8'h22);
    $display("done auto step");
  endtask : t_step
  task automatic t_clear;
    wr(`IRA_CTL_OFS, 8'h05);
    wr(`IRA_OFS_OFS, 8'h20); chk({7'h00, ana_rd_stb}, 8'h01);
    rd(`IRA_DAT_OFS, v); chk(v, 8'h11);
    chk({5'h00, tgt_rd_done, tgt_rd_clear, ana_rd_stb}, 8'h06);
    rd(`IRA_DAT_OFS, v); chk(v, 8'h00);
    wr(`IRA_CTL_OFS, 8'h04);
    wr(`IRA_OFS_OFS, 8'h21);
    rd(`IRA_DAT_OFS, v); chk({tgt_rd_clear, v[6:0]}, 8'h22);
    rd(`IRA_DAT_OFS, v); chk(v, 8'h22);
    $display("done clear on read");
  endtask : t_clear
  task automatic t_prefetch;
    wr(`IRA_CTL_OFS, 8'h07);
    wr(`IRA_OFS_OFS, 8'h21);
    rd(`IRA_DAT_OFS, v); chk(v, 8'h22);
    chk({7'h00, ana_rd_stb}, 8'h01);
    chk(tgt_addr, 8'h22);
    $display("done prefetch");
  endtask : t_prefetch
  // Offset write straight into an offset read, no idle cycle between
  task automatic t_back;
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= `IRA_OFS_OFS;
    reg_wdata <= 8'h3C;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, 8'h3C);
    $display("done back to back");
  endtask : t_back
  task automatic t_freeze;
    @(posedge mclk);
    ce <= 1'b0;
    wr(`IRA_OFS_OFS, 8'h55); chk(tgt_addr, 8'h3C);
    @(posedge mclk);
    ce <= 1'b1;
    rd(`IRA_OFS_OFS, v); chk(v, 8'h3C);
    $display("done freeze");
  endtask : t_freeze
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // Watchdog: a hang counts as a mismatch
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    t_reset();
    t_pages();
    t_step();
    t_clear();
    t_prefetch();
    t_back();
    t_freeze();
    finish_test();
  end
endmodule : indirect_register_access_bench
`default_nettype wire
